/* File: core/drive_power_pkg.sv */
//Contract
// [R1] Writes use only write-any-register; both read commands return the register.
// [R2] Write-any-register at address 0x000005 updates the retained non-volatile copy.
// [R3] Write-any-register at 0x070005 updates only the volatile copy.
// [R4] Read-any-register accepts either address and returns the register.
// [R5] Deep-sleep bit one, select high: enter deep power-down after any reset except software reset.
// [R6] Deep-sleep bit zero, select high: enter standby after any reset.
// [R7] Host always writes one into bit 3.
// [R8] Bits 7:5 select the I/O drive strength.
// [R9] Codes 000/100=45, 001=120, 010=90, 011=60, 101=30, 11x=20 ohms.
// [R10] Factory value is all zeros except bit 3: 45 ohms, standby.
// [R11] Bits 4, 1 and 0 read zero and do nothing in either copy.
// [R12] Select pulse of minimum width or hardware reset leaves deep power-down.
// [R13] Software reset ignores the deep-sleep bit and always ends in standby.
// [R14] Deep-sleep bit also decides the state after leaving hibernate.
// [R15] After power-up or hardware reset, volatile copy reloads from non-volatile.
package drive_power_pkg;

  // Clock rate and register addresses
  localparam int unsigned CLK_MHZ  = 20;
  localparam logic [23:0] ADDR_NV  = 24'h00_0005;
  localparam logic [23:0] ADDR_VOL = 24'h07_0005;

  // Field layout and factory value
  localparam int unsigned IMP_MSB     = 7;
  localparam int unsigned IMP_LSB     = 5;
  localparam int unsigned DEEP_BIT    = 2;
  localparam logic [7:0]  DPC_RESET   = 8'h08;
  localparam logic [7:0]  WRITE_MASK  = 8'hEC;

  // Deep power-down exit timing, least times rounded up to cycles
  localparam int unsigned CS_WAKE_MIN_NS = 100;
  localparam int unsigned DEEP_EXIT_NS   = 3000;
  localparam int unsigned CS_PULSE_CYC   = (CS_WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EXIT_CYC       = (DEEP_EXIT_NS * CLK_MHZ + 999) / 1000;

  // Typical impedances in ohms
  localparam logic [7:0] OHM_45  = 8'h2D;
  localparam logic [7:0] OHM_120 = 8'h78;
  localparam logic [7:0] OHM_90  = 8'h5A;
  localparam logic [7:0] OHM_60  = 8'h3C;
  localparam logic [7:0] OHM_30  = 8'h1E;
  localparam logic [7:0] OHM_20  = 8'h14;

  typedef enum logic [1:0]
  {
    CMD_NONE       = 2'h0,
    CMD_WRITE_ANY  = 2'h1,
    CMD_READ_DPC   = 2'h2,
    CMD_READ_ANY   = 2'h3
  } cmd_op_t;

  typedef struct packed
  {
    logic        valid;
    cmd_op_t     op;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } cmd_t;

  typedef struct packed
  {
    logic       valid;
    logic       hit;
    logic [7:0] data;
  } rsp_t;

  typedef enum logic [1:0]
  {
    PWR_BOOT      = 2'h0,
    PWR_STANDBY   = 2'h1,
    PWR_DEEP_DOWN = 2'h2,
    PWR_HIBERNATE = 2'h3
  } power_state_t;

  // Gray codes along the reset path to standby; entry to and exit from deep power-down flip two bits
  typedef enum logic [2:0]
  {
    ST_LOAD    = 3'h0,
    ST_FETCH   = 3'h1,
    ST_APPLY   = 3'h3,
    ST_STANDBY = 3'h2,
    ST_DEEP    = 3'h6,
    ST_EXIT    = 3'h7,
    ST_HIBER   = 3'h4
  } seq_state_t;

  // Impedance field to typical ohms
  function automatic logic [7:0] ohms_of(input logic [2:0] code);
    case (code)
      3'h1:    ohms_of = OHM_120;
      3'h2:    ohms_of = OHM_90;
      3'h3:    ohms_of = OHM_60;
      3'h5:    ohms_of = OHM_30;
      3'h6,
      3'h7:    ohms_of = OHM_20;
      default: ohms_of = OHM_45;
    endcase
  endfunction : ohms_of

endpackage : drive_power_pkg

/* File: core/nv_cell_store.sv */
`timescale 1ns/10ps
`default_nettype none
module nv_cell_store
#(
  parameter int unsigned WIDTH     = 8,
  parameter logic [7:0]  INIT_VAL  = drive_power_pkg::DPC_RESET
)
(
  // Clock, enable and factory initialisation
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             init_n,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port, data registered
  input  wire logic             rd_en,
  output var  logic [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] cell_q;

  // Retained cell: power-on reset does not touch it, only factory init
  always_ff @(posedge clk or negedge init_n)
  begin
    if (!init_n)
      cell_q <= INIT_VAL[WIDTH-1:0];
    else if (ce && wr_en)
      cell_q <= wr_data;
  end

  // Registered read so the caller sees data one edge after the request
  always_ff @(posedge clk or negedge init_n)
  begin
    if (!init_n)
      rd_data_q <= INIT_VAL[WIDTH-1:0];
    else if (ce && rd_en)
      rd_data_q <= cell_q;
  end

endmodule : nv_cell_store
`default_nettype wire

/* File: core/impedance_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module impedance_decode
(
  // Impedance field in, typical ohms out
  input  wire logic [2:0] code,
  output var  logic [7:0] ohms
);

  // Decode shared with the checks through the package function
  always_comb
  begin
    ohms = drive_power_pkg::ohms_of(code); // [R9]
  end

endmodule : impedance_decode
`default_nettype wire

/* File: core/drive_power_config_reg.sv */
`timescale 1ns/10ps
`default_nettype none
module drive_power_config_reg
#(
  parameter int unsigned CNT_W = 8
)
(
  // Clock, power-on reset and clock enable
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // Factory initialisation of the retained copy
  input  wire logic                         factory_init_n,
  // Decoded register command and its answer
  input  wire drive_power_pkg::cmd_t        cmd,
  output var  drive_power_pkg::rsp_t        rsp_q,
  // Reset and power-mode requests from the command front end
  input  wire logic                         hw_reset_req,
  input  wire logic                         sw_reset_req,
  input  wire logic                         hibernate_enter,
  input  wire logic                         hibernate_exit,
  // Chip select pin, asynchronous
  input  wire logic                         cs_n,
  // Power and drive status
  output var  drive_power_pkg::power_state_t power_state_q,
  output var  logic [2:0]                   drive_code_q,
  output var  logic [7:0]                   drive_ohms_q
);

  drive_power_pkg::seq_state_t state_q;
  logic                        sw_q;
  logic [7:0]                  vol_q;
  logic                        cs_n_meta_q;
  logic                        cs_n_sync_q;
  logic [CNT_W-1:0]            cs_low_cnt_q;
  logic [CNT_W-1:0]            exit_cnt_q;
  logic                        pend_valid_q;
  logic                        pend_nv_q;
  logic                        pend_hit_q;
  logic [7:0]                  nv_rd_data;
  logic [7:0]                  ohms;
  logic                        take;
  logic                        is_nv;
  logic                        is_vol;
  logic                        wr_nv;
  logic                        wr_vol;
  logic                        rd_take;
  logic                        rd_nv;
  logic                        rd_hit;
  logic                        nv_rd_en;
  logic [7:0]                  wdata_clean;

  // Chip select crosses into clk through two flops before any use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_n_meta_q <= 1'b1;
      cs_n_sync_q <= 1'b1;
    end
    else if (ce)
    begin
      cs_n_meta_q <= cs_n;
      cs_n_sync_q <= cs_n_meta_q;
    end
  end

  // Commands only in standby; resets in the same cycle take priority
  always_comb
  begin
    take        = ce && cmd.valid && (state_q == drive_power_pkg::ST_STANDBY)
                  && !hw_reset_req && !sw_reset_req;
    is_nv       = (cmd.addr == drive_power_pkg::ADDR_NV);
    is_vol      = (cmd.addr == drive_power_pkg::ADDR_VOL);
    wr_nv       = take && (cmd.op == drive_power_pkg::CMD_WRITE_ANY) && is_nv; // [R2]
    wr_vol      = take && (cmd.op == drive_power_pkg::CMD_WRITE_ANY) && is_vol; // [R3]
    rd_take     = take && ((cmd.op == drive_power_pkg::CMD_READ_DPC)
                  || (cmd.op == drive_power_pkg::CMD_READ_ANY)); // [R1]
    rd_nv       = rd_take && (cmd.op == drive_power_pkg::CMD_READ_ANY) && is_nv; // [R4]
    rd_hit      = (cmd.op == drive_power_pkg::CMD_READ_DPC) || is_nv || is_vol; // [R4]
    wdata_clean = cmd.wdata & drive_power_pkg::WRITE_MASK; // [R11]
    nv_rd_en    = (state_q == drive_power_pkg::ST_LOAD) || rd_nv;
  end

  // Retained copy; bit 3 is stored as the host wrote it
  nv_cell_store #(
    .WIDTH    (8),
    .INIT_VAL (drive_power_pkg::DPC_RESET)
  ) u_nv (
    .clk       (clk),
    .ce        (ce),
    .init_n    (factory_init_n),
    .wr_en     (wr_nv),
    .wr_data   (wdata_clean),
    .rd_en     (nv_rd_en),
    .rd_data_q (nv_rd_data)
  );

  // Reset, power-down and hibernate sequencing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= drive_power_pkg::ST_LOAD; // [R15]
      sw_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (hw_reset_req)
      begin
        state_q <= drive_power_pkg::ST_LOAD; // [R12]
        sw_q    <= 1'b0;
      end
      else if (sw_reset_req)
      begin
        state_q <= drive_power_pkg::ST_LOAD;
        sw_q    <= 1'b1; // [R13]
      end
      else
      begin
        case (state_q)
          drive_power_pkg::ST_LOAD:
            state_q <= drive_power_pkg::ST_FETCH;
          drive_power_pkg::ST_FETCH:
            state_q <= drive_power_pkg::ST_APPLY;
          drive_power_pkg::ST_APPLY:
          begin
            // Select low at this point means the host is busy: stay awake
            if (vol_q[drive_power_pkg::DEEP_BIT] && cs_n_sync_q && !sw_q)
              state_q <= drive_power_pkg::ST_DEEP; // [R5]
            else
              state_q <= drive_power_pkg::ST_STANDBY; // [R6] [R13]
          end
          drive_power_pkg::ST_STANDBY:
            if (hibernate_enter)
              state_q <= drive_power_pkg::ST_HIBER;
          drive_power_pkg::ST_HIBER:
            if (hibernate_exit)
            begin
              state_q <= drive_power_pkg::ST_LOAD; // [R14]
              sw_q    <= 1'b0;
            end
          drive_power_pkg::ST_DEEP:
            if (cs_n_sync_q && (cs_low_cnt_q >= CNT_W'(drive_power_pkg::CS_PULSE_CYC)))
              state_q <= drive_power_pkg::ST_EXIT; // [R12]
          drive_power_pkg::ST_EXIT:
            if (exit_cnt_q == CNT_W'(drive_power_pkg::EXIT_CYC - 1))
              state_q <= drive_power_pkg::ST_STANDBY; // [R12]
          default:
            state_q <= drive_power_pkg::ST_LOAD;
        endcase
      end
    end
  end

  // Width of the wake pulse; a short glitch restarts the count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cs_low_cnt_q <= '0;
    else if (ce)
    begin
      if (state_q != drive_power_pkg::ST_DEEP || cs_n_sync_q)
        cs_low_cnt_q <= '0;
      else if (cs_low_cnt_q != '1)
        cs_low_cnt_q <= cs_low_cnt_q + 1'b1; // [R12]
    end
  end

  // Exit delay before the device answers again
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      exit_cnt_q <= '0;
    else if (ce)
    begin
      if (state_q == drive_power_pkg::ST_EXIT)
        exit_cnt_q <= exit_cnt_q + 1'b1;
      else
        exit_cnt_q <= '0;
    end
  end

  // Volatile working copy: reloaded on each reset, written at its own address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      vol_q <= drive_power_pkg::DPC_RESET; // [R10]
    else if (ce)
    begin
      if (state_q == drive_power_pkg::ST_FETCH)
        vol_q <= nv_rd_data & drive_power_pkg::WRITE_MASK; // [R15] [R11]
      else if (wr_vol)
        vol_q <= wdata_clean; // [R3]
    end
  end

  // Read pipeline: the retained copy needs one edge to come out
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_valid_q <= 1'b0;
      pend_nv_q    <= 1'b0;
      pend_hit_q   <= 1'b0;
    end
    else if (ce)
    begin
      pend_valid_q <= rd_take;
      pend_nv_q    <= rd_nv;
      pend_hit_q   <= rd_hit;
    end
  end

  // Answer word; an unknown read-any address reads zero with hit low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rsp_q <= '0;
    else if (ce)
    begin
      rsp_q.valid <= pend_valid_q;
      rsp_q.hit   <= pend_valid_q && pend_hit_q;
      if (!pend_valid_q || !pend_hit_q)
        rsp_q.data <= 8'h00;
      else if (pend_nv_q)
        rsp_q.data <= nv_rd_data; // [R4]
      else
        rsp_q.data <= vol_q; // [R1]
    end
  end

  impedance_decode u_imp (
    .code (vol_q[drive_power_pkg::IMP_MSB:drive_power_pkg::IMP_LSB]),
    .ohms (ohms)
  );

  // Drive strength follows the volatile copy once it has been reloaded
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_code_q <= 3'h0;
      drive_ohms_q <= drive_power_pkg::OHM_45; // [R10]
    end
    else if (ce && state_q != drive_power_pkg::ST_LOAD
             && state_q != drive_power_pkg::ST_FETCH)
    begin
      drive_code_q <= vol_q[drive_power_pkg::IMP_MSB:drive_power_pkg::IMP_LSB]; // [R8]
      drive_ohms_q <= ohms; // [R9]
    end
  end

  // Reported power mode, one edge behind the sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      power_state_q <= drive_power_pkg::PWR_BOOT;
    else if (ce)
    begin
      case (state_q)
        drive_power_pkg::ST_STANDBY: power_state_q <= drive_power_pkg::PWR_STANDBY;
        drive_power_pkg::ST_DEEP,
        drive_power_pkg::ST_EXIT:    power_state_q <= drive_power_pkg::PWR_DEEP_DOWN;
        drive_power_pkg::ST_HIBER:   power_state_q <= drive_power_pkg::PWR_HIBERNATE;
        default:                     power_state_q <= drive_power_pkg::PWR_BOOT;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_vol_write_own: assert property ( // [R3]
    wr_vol |=> vol_q == ($past(cmd.wdata) & drive_power_pkg::WRITE_MASK))
    else $error("volatile write not stored");

  a_nv_write_keeps: assert property ( // [R2]
    (wr_nv && !wr_vol) |=> $stable(vol_q))
    else $error("non-volatile write changed volatile copy");

  a_read_answer_one: assert property ( // [R4]
    rd_take ##1 ce |=> rsp_q.valid && rsp_q.hit == $past(pend_hit_q))
    else $error("read not answered next cycle");

  a_deep_entry_bit: assert property ( // [R5]
    (ce && !hw_reset_req && !sw_reset_req && state_q == drive_power_pkg::ST_APPLY
     && vol_q[drive_power_pkg::DEEP_BIT] && cs_n_sync_q && !sw_q)
    |=> state_q == drive_power_pkg::ST_DEEP)
    else $error("deep power-down not entered");

  a_standby_entry_bit: assert property ( // [R6]
    (ce && !hw_reset_req && !sw_reset_req && state_q == drive_power_pkg::ST_APPLY
     && !vol_q[drive_power_pkg::DEEP_BIT])
    |=> state_q == drive_power_pkg::ST_STANDBY)
    else $error("standby not entered");

  a_reserved_zero: assert property ( // [R11]
    vol_q[4] == 1'b0 && vol_q[1] == 1'b0 && vol_q[0] == 1'b0)
    else $error("reserved bit set in volatile copy");

  a_drive_follows: assert property ( // [R9]
    (ce && state_q == drive_power_pkg::ST_STANDBY)
    |=> drive_ohms_q == drive_power_pkg::ohms_of($past(vol_q[7:5])))
    else $error("drive strength does not match field");

  a_soft_reset_awake: assert property ( // [R13]
    (sw_reset_req && ce && !hw_reset_req)
    ##1 (ce && !hw_reset_req && !sw_reset_req)[*3]
    |=> state_q == drive_power_pkg::ST_STANDBY)
    else $error("software reset did not end in standby");

  a_wake_pulse_width: assert property ( // [R12]
    (state_q == drive_power_pkg::ST_DEEP) ##1 (state_q == drive_power_pkg::ST_EXIT)
    |-> $past(cs_low_cnt_q) >= CNT_W'(drive_power_pkg::CS_PULSE_CYC))
    else $error("left deep power-down on a short pulse");

  a_reload_first: assert property ( // [R15]
    (ce && !hw_reset_req && !sw_reset_req && state_q == drive_power_pkg::ST_FETCH)
    |=> vol_q == ($past(nv_rd_data) & drive_power_pkg::WRITE_MASK))
    else $error("volatile copy not reloaded");

  c_deep_entry: cover property (state_q == drive_power_pkg::ST_DEEP);
  c_deep_exit: cover property (
    state_q == drive_power_pkg::ST_EXIT ##1 state_q == drive_power_pkg::ST_STANDBY);
  c_nv_read: cover property (rd_nv ##2 rsp_q.valid);
  c_hibernate_out: cover property (state_q == drive_power_pkg::ST_HIBER && hibernate_exit);

endmodule : drive_power_config_reg
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model
(
  // Clock
  input  wire logic                  clk,
  // Command out, answer in
  output var  drive_power_pkg::cmd_t cmd,
  input  wire drive_power_pkg::rsp_t rsp
);
  // Idle until the first request
  initial cmd = '0;

  // Hold a request over its take edge, then release; lines invert so stale values never match
  task automatic issue(input drive_power_pkg::cmd_op_t op, input logic [23:0] addr,
                       input logic [7:0] data);
    @(posedge clk);
    cmd <= '{1'b1, op, addr, data};
    @(posedge clk);
    cmd <= '{1'b0, drive_power_pkg::CMD_NONE, ~addr, ~data};
  endtask : issue

  // Only write-any changes the register, and bit 3 always goes out as one
  task automatic write_reg(input logic [23:0] addr, input logic [7:0] data);
    issue(drive_power_pkg::CMD_WRITE_ANY, addr, data | 8'h08);
  endtask : write_reg

  // Answer lands one edge after the take edge and stands for a single cycle
  task automatic read_reg(input drive_power_pkg::cmd_op_t op, input logic [23:0] addr,
                          output logic v, output logic h, output logic [7:0] d);
    issue(op, addr, 8'h00);
    @(posedge clk);
    #1;
    v = rsp.valid;
    h = rsp.hit;
    d = rsp.data;
  endtask : read_reg
endmodule : host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                          clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          factory_init_n = 1'b0;
  logic                          hw_reset_req = 1'b0;
  logic                          sw_reset_req = 1'b0;
  logic                          hibernate_enter = 1'b0;
  logic                          hibernate_exit = 1'b0;
  logic                          cs_n = 1'b1;
  logic                          ce = 1'b1;
  drive_power_pkg::cmd_t         cmd;
  drive_power_pkg::rsp_t         rsp_q;
  drive_power_pkg::power_state_t power_state_q;
  logic [2:0]                    drive_code_q;
  logic [7:0]                    drive_ohms_q;
  int                            miscompares = 0;
  int                            n_compared = 0;
  int                            nv_m = 8;
  int                            vol_m = 8;
  int                            exp_q [$];
  int                            ohm_tab [8] = '{45, 120, 90, 60, 45, 30, 20, 20};
  logic [31:0]                   seed = 32'h0000_0056;

  // 20 MHz clock
  always #25 clk = ~clk;

  drive_power_config_reg dut
  (
    .clk(clk), .rst_n(rst_n), .ce(ce), .factory_init_n(factory_init_n),
    .cmd(cmd), .rsp_q(rsp_q), .hw_reset_req(hw_reset_req), .sw_reset_req(sw_reset_req),
    .hibernate_enter(hibernate_enter), .hibernate_exit(hibernate_exit), .cs_n(cs_n),
    .power_state_q(power_state_q), .drive_code_q(drive_code_q), .drive_ohms_q(drive_ohms_q)
  );

  host_model host (.clk(clk), .cmd(cmd), .rsp(rsp_q));

  // Pseudo-random source for the don't-care bits of each impedance-sweep write
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Read through the host and compare with the model's copies
  task automatic read_check(input drive_power_pkg::cmd_op_t op, input logic [23:0] addr);
    logic       v;
    logic       h;
    logic [7:0] d;
    logic       eh;
    logic [7:0] ed;
    eh = (op == drive_power_pkg::CMD_READ_DPC) || addr == 24'h00_0005 || addr == 24'h07_0005;
    ed = !eh ? 8'h00 : (op == drive_power_pkg::CMD_READ_ANY && addr == 24'h00_0005) ?
         nv_m[7:0] : vol_m[7:0];
    exp_q.push_back(ed);
    host.read_reg(op, addr, v, h, d);
    check("read valid", v, 1'b1);
    check("read hit", h, eh);
    check("read data", d, exp_q.pop_front());
  endtask : read_check

  task automatic check_drive;
    check("drive code", drive_code_q, vol_m[7:5]);
    check("drive ohms", drive_ohms_q, ohm_tab[vol_m[7:5]]);
  endtask : check_drive

  // One-cycle request pulse: 0 hardware reset, 1 software reset, 2 hibernate in, 3 out
  task automatic reset_then(input int which, input drive_power_pkg::power_state_t s);
    @(posedge clk);
    hw_reset_req <= (which == 0);
    sw_reset_req <= (which == 1);
    hibernate_enter <= (which == 2);
    hibernate_exit <= (which == 3);
    @(posedge clk);
    {hw_reset_req, sw_reset_req, hibernate_enter, hibernate_exit} <= 4'h0;
    if (which != 2)
      vol_m = nv_m;
    repeat (8) @(posedge clk);
    #1;
    check("power state", power_state_q, s);
  endtask : reset_then

  // Chip-select pulse longer than the minimum, then wait out the exit delay
  // Status is sampled 1 ns after each edge so the count never races the flops
  task automatic leave_deep;
    int i;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    for (i = 0; i < 100 && power_state_q !== drive_power_pkg::PWR_STANDBY; i++)
    begin
      @(posedge clk);
      #1;
    end
    check("deep exit", power_state_q, drive_power_pkg::PWR_STANDBY);
    check("deep exit cycles", i, drive_power_pkg::EXIT_CYC + 4);
    check_drive();
  endtask : leave_deep

  // Main sequence
  initial
  begin
    logic [7:0] wd;
    logic       v;
    logic       h;
    logic [7:0] d;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    factory_init_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check("boot state", power_state_q, drive_power_pkg::PWR_STANDBY);
    check_drive();
    read_check(drive_power_pkg::CMD_READ_DPC, 24'h07_0005);
    read_check(drive_power_pkg::CMD_READ_ANY, 24'h00_0005);
    read_check(drive_power_pkg::CMD_READ_ANY, 24'h07_0005);
    read_check(drive_power_pkg::CMD_READ_ANY, 24'h00_0006);
    $display("test reset_defaults done");
    for (int code = 0; code < 8; code++)
    begin
      seed = xs(seed);
      wd = {code[2:0], seed[4:3], 1'b0, seed[1:0]};
      host.write_reg(24'h07_0005, wd);
      vol_m = (wd | 8'h08) & 8'hEC;
      read_check(drive_power_pkg::CMD_READ_DPC, 24'h07_0005);
      read_check(drive_power_pkg::CMD_READ_ANY, 24'h00_0005);
      check_drive();
    end
    host.write_reg(24'h00_0006, 8'hFF);
    read_check(drive_power_pkg::CMD_READ_ANY, 24'h07_0005);
    $display("test impedance_sweep done");
    host.write_reg(24'h00_0005, 8'hA7);
    nv_m = 8'hAC;
    read_check(drive_power_pkg::CMD_READ_ANY, 24'h00_0005);
    check_drive();
    reset_then(0, drive_power_pkg::PWR_DEEP_DOWN);
    host.read_reg(drive_power_pkg::CMD_READ_DPC, 24'h07_0005, v, h, d);
    check("read in deep", v, 1'b0);
    leave_deep();
    reset_then(1, drive_power_pkg::PWR_STANDBY);
    reset_then(2, drive_power_pkg::PWR_HIBERNATE);
    reset_then(3, drive_power_pkg::PWR_DEEP_DOWN);
    leave_deep();
    $display("test deep_sleep_paths done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    vol_m = nv_m;
    repeat (8) @(posedge clk);
    #1;
    check("por state", power_state_q, drive_power_pkg::PWR_DEEP_DOWN);
    leave_deep();
    @(posedge clk);
    cs_n <= 1'b0;
    reset_then(0, drive_power_pkg::PWR_STANDBY);
    @(posedge clk);
    cs_n <= 1'b1;
    host.write_reg(24'h00_0005, 8'h20);
    nv_m = 8'h28;
    reset_then(0, drive_power_pkg::PWR_STANDBY);
    check_drive();
    $display("test power_on_and_select done");
    // Enable low must swallow a reset request and freeze every flop
    @(posedge clk);
    ce <= 1'b0;
    hw_reset_req <= 1'b1;
    repeat (4) @(posedge clk);
    hw_reset_req <= 1'b0;
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("frozen state", power_state_q, drive_power_pkg::PWR_STANDBY);
    check_drive();
    read_check(drive_power_pkg::CMD_READ_DPC, 24'h07_0005);
    $display("test clock_enable_freeze done");
    complete_run();
  end

  // Watchdog, far beyond the expected run of under a thousand cycles
  initial
  begin
    #(50 * 5000);
    miscompares++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
